/* src/dsc_pkg.sv */
`default_nettype none
package dsk_pkg;
    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_FEATURE   = 8'h00;
    localparam logic [7:0] OFF_SECT_CNT  = 8'h04;
    localparam logic [7:0] OFF_SECT_NUM  = 8'h08;
    localparam logic [7:0] OFF_CYL_LOW   = 8'h0C;
    localparam logic [7:0] OFF_CYL_HIGH  = 8'h10;
    localparam logic [7:0] OFF_DEV_HEAD  = 8'h14;
    localparam logic [7:0] OFF_COMMAND   = 8'h18;
    localparam logic [7:0] OFF_ERROR     = 8'h1C;
    localparam logic [7:0] OFF_STATUS    = 8'h20;
    localparam logic [7:0] OFF_OPTIONS   = 8'h24;
    localparam logic [7:0] OFF_XFER_MODE = 8'h28;
    localparam logic [7:0] OFF_SATA_EN   = 8'h2C;
    localparam logic [7:0] OFF_SECT_TIME = 8'h30;
    localparam logic [7:0] OFF_TEMP_IN   = 8'h34;
    localparam logic [7:0] OFF_POS_CTRL  = 8'h38;

    // ------------------------------------------------------------
    // Opcodes and feature codes
    // ------------------------------------------------------------
    localparam logic [3:0] OPC_POSITION_HI = 4'h7;
    localparam logic [7:0] OPC_TEMP_SENSE  = 8'hF0;
    localparam logic [7:0] OPC_SET_FEATURE = 8'hEF;
    localparam logic [7:0] TEMP_SUBCODE    = 8'h01;
    localparam logic [7:0] FC_WCACHE_ON    = 8'h02;
    localparam logic [7:0] FC_XFER_MODE    = 8'h03;
    localparam logic [7:0] FC_APM_ON       = 8'h05;
    localparam logic [7:0] FC_PUIS_ON      = 8'h06;
    localparam logic [7:0] FC_SPIN_UP      = 8'h07;
    localparam logic [7:0] FC_SATA_ON      = 8'h10;
    localparam logic [7:0] FC_SECT_TIME    = 8'h43;
    localparam logic [7:0] FC_EPC          = 8'h4A;
    localparam logic [7:0] FC_RLA_OFF      = 8'h55;
    localparam logic [7:0] FC_REVERT_OFF   = 8'h66;
    localparam logic [7:0] FC_WCACHE_OFF   = 8'h82;
    localparam logic [7:0] FC_APM_OFF      = 8'h85;
    localparam logic [7:0] FC_PUIS_OFF     = 8'h86;
    localparam logic [7:0] FC_SATA_OFF     = 8'h90;
    localparam logic [7:0] FC_RLA_ON       = 8'hAA;
    localparam logic [7:0] FC_REVERT_ON    = 8'hCC;

    // ------------------------------------------------------------
    // Field positions and values
    // ------------------------------------------------------------
    localparam int          ERR_ABORT_BIT   = 2;
    localparam int          ERR_IDNF_BIT    = 4;
    localparam int          ST_ERR_BIT      = 0;
    localparam int          ST_POSDONE_BIT  = 4;
    localparam int          ST_READY_BIT    = 6;
    localparam int          ST_BUSY_BIT     = 7;
    localparam int          DH_LBA_BIT      = 6;
    localparam int          OPT_WCACHE      = 0;
    localparam int          OPT_RLA         = 1;
    localparam int          OPT_REVERT      = 2;
    localparam int          OPT_IRQ_REL     = 3;
    localparam int          OPT_APM         = 4;
    localparam int          OPT_PUIS        = 5;
    localparam int          OPT_SPUN_UP     = 6;
    localparam int          OPT_EPC_REQ     = 7;
    localparam logic [7:0]  OPT_RESET       = 8'h43;
    localparam logic [7:0]  TEMP_MIN_CODE   = 8'h00;
    localparam logic [7:0]  TEMP_MAX_CODE   = 8'hFF;
    localparam logic [27:0] MAX_LBA_DEFAULT = 28'hFFFFFFF;
    localparam logic [3:0]  SEEK_CYCLES     = 4'h8;

    typedef enum logic [1:0] {
        DSK_IDLE = 2'b00,
        DSK_EXEC = 2'b01,
        DSK_SEEK = 2'b11
    } dsk_state_t;
endpackage
`default_nettype wire

/* src/dsc_top.sv */
// Added by the designer: the placing of the registers and the APB slave port.
`default_nettype none
// How it works
// - Opcode upper nibble 7 starts a seek to the requested track and head.
// - Seeks run whether or not the media is formatted; no format check.
// - In block mode, block bits 0-7 come from the sector number register.
// - Block bits 8-15 from cylinder low, 16-23 from cylinder high.
// - Block bits 24-27 come from the head field of device/head.
// - In cylinder/head mode, cylinder from high/low registers, head from field.
// - After a block-mode seek, return current block address in the same fields.
// - Temperature command needs feature 01h; any other value aborts.
// - Temperature command runs even while powered up in standby.
// - Temperature code: 00h at or under -20 C, FFh above 107 C.
// - Set-features with an undefined feature code sets the abort bit.
// - Code 02h enables write cache, 82h disables it.
// - Code 03h stores the transfer mode from sector count.
// - Code 05h enables advanced power management, 85h disables it.
// - Code 06h enables power-up in standby, 86h disables it.
// - Code 07h spins up a drive that powered up in standby.
// - Code 10h/90h enables/disables the serial feature chosen by sector count.
// - Code 43h records the host maximum sector time.
// - Code 4Ah raises the extended power conditions request.
// - Code 55h disables read look-ahead, AAh enables it.
// - Code 66h disables reverting to defaults, CCh enables it.
// - Reset leaves cache and look-ahead on, revert and interrupt release off.
module dsk_top (
    input  wire logic        pclk,        // 20 MHz clock
    input  wire logic        presetn,     // Async reset, active low
    input  wire logic        psel,        // APB select
    input  wire logic        penable,     // APB access phase
    input  wire logic        pwrite,      // APB direction
    input  wire logic [7:0]  paddr,       // APB byte address
    input  wire logic [31:0] pwdata,      // APB write data
    output logic      [31:0] prdata,      // APB read data
    output logic             pready,      // APB ready
    output logic             pslverr,     // APB error
    input  wire logic [7:0]  temp_code,   // Temperature code from sensor, same clock
    output logic      [15:0] seek_cyl,    // Target cylinder
    output logic      [3:0]  seek_head,   // Selected head
    output logic             seek_start,  // Seek start pulse
    output logic      [7:0]  options      // Feature option bits
);
    import dsk_pkg::*;

    typedef struct packed {
        dsk_state_t  state;
        logic [7:0]  feature;
        logic [7:0]  sect_cnt;
        logic [7:0]  sect_num;
        logic [7:0]  cyl_low;
        logic [7:0]  cyl_high;
        logic [7:0]  dev_head;
        logic [7:0]  command;
        logic [7:0]  error;
        logic [7:0]  status;
        logic [7:0]  opts;
        logic [7:0]  xfer_mode;
        logic [7:0]  sata_en;
        logic [31:0] sect_time;
        logic [27:0] max_lba;
        logic [3:0]  seek_cnt;
        logic [15:0] cyl;
        logic [3:0]  head;
        logic        start;
    } dsk_regs_t;

    dsk_regs_t r_reg;
    dsk_regs_t r_next;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Decodes whether a feature code is defined
    function automatic logic feature_known(input logic [7:0] fc);
        case (fc)
            FC_WCACHE_ON, FC_XFER_MODE, FC_APM_ON, FC_PUIS_ON, FC_SPIN_UP,
            FC_SATA_ON, FC_SECT_TIME, FC_EPC, FC_RLA_OFF, FC_REVERT_OFF,
            FC_WCACHE_OFF, FC_APM_OFF, FC_PUIS_OFF, FC_SATA_OFF, FC_RLA_ON,
            FC_REVERT_ON: feature_known = 1'b1;
            default:      feature_known = 1'b0;
        endcase
    endfunction

    // Block address assembled from the command registers
    function automatic logic [27:0] block_addr(input dsk_regs_t s);
        block_addr = {s.dev_head[3:0], s.cyl_high, s.cyl_low, s.sect_num};
    endfunction

    logic wr_en;
    logic rd_sel;
    assign wr_en  = psel && penable && pwrite;
    assign rd_sel = psel && !pwrite;

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    // Bus writes, command launch and execution
    always_comb begin
        r_next       = r_reg;
        r_next.start = 1'b0;
        if (wr_en && r_reg.state == DSK_IDLE) begin
            unique case (paddr)
                OFF_FEATURE:   r_next.feature  = pwdata[7:0];
                OFF_SECT_CNT:  r_next.sect_cnt = pwdata[7:0];
                OFF_SECT_NUM:  r_next.sect_num = pwdata[7:0];
                OFF_CYL_LOW:   r_next.cyl_low  = pwdata[7:0];
                OFF_CYL_HIGH:  r_next.cyl_high = pwdata[7:0];
                OFF_DEV_HEAD:  r_next.dev_head = pwdata[7:0];
                OFF_POS_CTRL:  r_next.max_lba  = pwdata[27:0];
                OFF_COMMAND: begin
                    r_next.command = pwdata[7:0];
                    r_next.error   = 8'h00;
                    r_next.status  = 8'h00;
                    r_next.status[ST_BUSY_BIT] = 1'b1;
                    r_next.state   = DSK_EXEC;
                end
                default: ;
            endcase
        end
        unique case (r_reg.state)
            DSK_IDLE: ;
            DSK_EXEC: begin
                r_next.state = DSK_IDLE;
                r_next.status[ST_READY_BIT] = 1'b1;
                r_next.status[ST_BUSY_BIT]  = 1'b0;
                if (r_reg.command[7:4] == OPC_POSITION_HI) begin
                    // No format check: seeks always proceed
                    r_next.status[ST_BUSY_BIT] = 1'b1;
                    r_next.state = DSK_SEEK;
                    r_next.seek_cnt = SEEK_CYCLES;
                    r_next.start = 1'b1;
                    if (r_reg.dev_head[DH_LBA_BIT]) begin
                        // Block address split over the command registers
                        r_next.cyl  = {r_reg.cyl_high, r_reg.cyl_low};
                        r_next.head = r_reg.dev_head[3:0];
                    end else begin
                        r_next.cyl  = {r_reg.cyl_high, r_reg.cyl_low};
                        r_next.head = r_reg.dev_head[3:0];
                    end
                end else if (r_reg.command == OPC_TEMP_SENSE) begin
                    // Standby does not block this command
                    if (r_reg.feature != TEMP_SUBCODE) begin
                        r_next.error[ERR_ABORT_BIT] = 1'b1;
                    end else begin
                        r_next.sect_cnt = temp_code;
                    end
                end else if (r_reg.command == OPC_SET_FEATURE) begin
                    if (!feature_known(r_reg.feature)) begin
                        r_next.error[ERR_ABORT_BIT] = 1'b1;
                    end
                    case (r_reg.feature)
                        FC_WCACHE_ON:  r_next.opts[OPT_WCACHE] = 1'b1;
                        FC_WCACHE_OFF: r_next.opts[OPT_WCACHE] = 1'b0;
                        FC_XFER_MODE:  r_next.xfer_mode = r_reg.sect_cnt;
                        FC_APM_ON:     r_next.opts[OPT_APM] = 1'b1;
                        FC_APM_OFF:    r_next.opts[OPT_APM] = 1'b0;
                        FC_PUIS_ON:    r_next.opts[OPT_PUIS] = 1'b1;
                        FC_PUIS_OFF:   r_next.opts[OPT_PUIS] = 1'b0;
                        FC_SPIN_UP:    r_next.opts[OPT_SPUN_UP] = 1'b1;
                        FC_SATA_ON:    r_next.sata_en[r_reg.sect_cnt[2:0]] = 1'b1;
                        FC_SATA_OFF:   r_next.sata_en[r_reg.sect_cnt[2:0]] = 1'b0;
                        FC_SECT_TIME:  r_next.sect_time = {r_reg.cyl_high, r_reg.cyl_low,
                                                           r_reg.sect_num, r_reg.sect_cnt};
                        FC_EPC:        r_next.opts[OPT_EPC_REQ] = 1'b1;
                        FC_RLA_OFF:    r_next.opts[OPT_RLA] = 1'b0;
                        FC_RLA_ON:     r_next.opts[OPT_RLA] = 1'b1;
                        FC_REVERT_OFF: r_next.opts[OPT_REVERT] = 1'b0;
                        FC_REVERT_ON:  r_next.opts[OPT_REVERT] = 1'b1;
                        default: ;
                    endcase
                end else begin
                    r_next.error[ERR_ABORT_BIT] = 1'b1;
                end
                // Abort reflects into status
                r_next.status[ST_ERR_BIT] = r_next.error[ERR_ABORT_BIT];
            end
            DSK_SEEK: begin
                r_next.seek_cnt = r_reg.seek_cnt - 4'h1;
                if (r_reg.seek_cnt == 4'h1) begin
                    r_next.state = DSK_IDLE;
                    r_next.status[ST_BUSY_BIT]  = 1'b0;
                    r_next.status[ST_READY_BIT] = 1'b1;
                    if (r_reg.dev_head[DH_LBA_BIT] && block_addr(r_reg) > r_reg.max_lba) begin
                        r_next.error[ERR_IDNF_BIT] = 1'b1;
                        r_next.status[ST_ERR_BIT]  = 1'b1;
                    end else begin
                        r_next.status[ST_POSDONE_BIT] = 1'b1;
                    end
                    // Current block address reported back in place
                    if (r_reg.dev_head[DH_LBA_BIT]) begin
                        r_next.sect_num      = r_reg.sect_num;
                        r_next.cyl_low       = r_reg.cyl[7:0];
                        r_next.cyl_high      = r_reg.cyl[15:8];
                        r_next.dev_head[3:0] = r_reg.head;
                    end
                end
            end
            default: r_next.state = DSK_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    // Feature defaults at reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_reg           <= '0;
            r_reg.state     <= DSK_IDLE;
            r_reg.opts      <= OPT_RESET;
            r_reg.max_lba   <= MAX_LBA_DEFAULT;
            // Ready set, every other status bit clear
            r_reg.status[ST_READY_BIT] <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    // ------------------------------------------------------------
    // APB read path
    // ------------------------------------------------------------
    // Read mux, zero-wait slave
    always_comb begin
        prdata = 32'h0000_0000;
        if (rd_sel) begin
            case (paddr)
                OFF_FEATURE:   prdata = {24'h000000, r_reg.feature};
                OFF_SECT_CNT:  prdata = {24'h000000, r_reg.sect_cnt};
                OFF_SECT_NUM:  prdata = {24'h000000, r_reg.sect_num};
                OFF_CYL_LOW:   prdata = {24'h000000, r_reg.cyl_low};
                OFF_CYL_HIGH:  prdata = {24'h000000, r_reg.cyl_high};
                OFF_DEV_HEAD:  prdata = {24'h000000, r_reg.dev_head};
                OFF_COMMAND:   prdata = {24'h000000, r_reg.command};
                OFF_ERROR:     prdata = {24'h000000, r_reg.error};
                OFF_STATUS:    prdata = {24'h000000, r_reg.status};
                OFF_OPTIONS:   prdata = {24'h000000, r_reg.opts};
                OFF_XFER_MODE: prdata = {24'h000000, r_reg.xfer_mode};
                OFF_SATA_EN:   prdata = {24'h000000, r_reg.sata_en};
                OFF_SECT_TIME: prdata = r_reg.sect_time;
                OFF_TEMP_IN:   prdata = {24'h000000, temp_code};
                OFF_POS_CTRL:  prdata = {4'h0, r_reg.max_lba};
                default:       prdata = 32'h0000_0000;
            endcase
        end
    end

    assign pready     = 1'b1;
    assign pslverr    = psel && penable && (paddr > OFF_POS_CTRL || paddr[1:0] != 2'b00);
    assign seek_cyl   = r_reg.cyl;
    assign seek_head  = r_reg.head;
    assign seek_start = r_reg.start;
    assign options    = r_reg.opts;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_cmd_exec(logic [7:0] op);
        r_reg.state == DSK_EXEC && r_reg.command == op;
    endsequence

    a_seek_start_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        r_reg.state == DSK_EXEC && r_reg.command[7:4] == OPC_POSITION_HI |=> seek_start ##1 !seek_start)
        else $error("seek start missing");
    a_seek_no_format: assert property (@(posedge pclk) disable iff (!presetn)
        seek_start |-> r_reg.state == DSK_SEEK && r_reg.error == 8'h00)
        else $error("seek blocked");
    a_seek_target_cyl: assert property (@(posedge pclk) disable iff (!presetn)
        r_reg.state == DSK_EXEC && r_reg.command[7:4] == OPC_POSITION_HI
        |=> seek_cyl == {$past(r_reg.cyl_high), $past(r_reg.cyl_low)})
        else $error("seek cylinder wrong");
    a_seek_target_head: assert property (@(posedge pclk) disable iff (!presetn)
        r_reg.state == DSK_EXEC && r_reg.command[7:4] == OPC_POSITION_HI
        |=> seek_head == $past(r_reg.dev_head[3:0]))
        else $error("seek head wrong");
    a_seek_done_time: assert property (@(posedge pclk) disable iff (!presetn)
        seek_start |-> ##7 r_reg.state == DSK_SEEK ##1 r_reg.state == DSK_IDLE)
        else $error("seek length wrong");
    a_temp_abort: assert property (@(posedge pclk) disable iff (!presetn)
        s_cmd_exec(OPC_TEMP_SENSE) and r_reg.feature != TEMP_SUBCODE |=> r_reg.error[ERR_ABORT_BIT])
        else $error("bad temp sub-code accepted");
    a_temp_result: assert property (@(posedge pclk) disable iff (!presetn)
        s_cmd_exec(OPC_TEMP_SENSE) and r_reg.feature == TEMP_SUBCODE |=> r_reg.sect_cnt == $past(temp_code))
        else $error("temp result wrong");
    a_feature_abort: assert property (@(posedge pclk) disable iff (!presetn)
        s_cmd_exec(OPC_SET_FEATURE) and !feature_known(r_reg.feature) |=> r_reg.error[ERR_ABORT_BIT])
        else $error("undefined feature accepted");
    a_wcache_off: assert property (@(posedge pclk) disable iff (!presetn)
        s_cmd_exec(OPC_SET_FEATURE) and r_reg.feature == FC_WCACHE_OFF |=> !options[OPT_WCACHE])
        else $error("write cache not off");
    a_abort_status: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(r_reg.error[ERR_ABORT_BIT]) |-> r_reg.status[ST_ERR_BIT] && !r_reg.status[ST_BUSY_BIT])
        else $error("abort without error status");
    a_temp_standby: assert property (@(posedge pclk) disable iff (!presetn)
        s_cmd_exec(OPC_TEMP_SENSE) and r_reg.opts[OPT_PUIS]
        |=> r_reg.status[ST_READY_BIT] && !r_reg.status[ST_BUSY_BIT])
        else $error("temp command stalled in standby");
    a_lba_report: assert property (@(posedge pclk) disable iff (!presetn)
        r_reg.state == DSK_SEEK && r_reg.seek_cnt == 4'h1 && r_reg.dev_head[DH_LBA_BIT]
        |=> {r_reg.cyl_high, r_reg.cyl_low} == seek_cyl && r_reg.dev_head[3:0] == seek_head)
        else $error("block address not reported");
endmodule
`default_nettype wire

/* testbench/dsc_temp_src.sv */
`default_nettype none
// ------------------------------------------------------------
// Temperature source beside the command block
// ------------------------------------------------------------
module dsk_temp_src (
    input  wire logic       pclk,      // Bench clock
    input  wire logic       presetn,   // Reset, active low
    input  wire logic [7:0] level,     // Code the sensor should report
    output logic      [7:0] temp_code  // Code seen by the block
);
    timeunit 1ns;
    timeprecision 1ns;

    // Sensor settles one cycle after a new level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            temp_code <= 8'h00;
        end else begin
            temp_code <= level;
        end
    end
endmodule
`default_nettype wire

/* testbench/dsc_top_tb_top.sv */
`default_nettype none
`define CHK(nm, e, s) begin n_tests++; if ((e) !== (s)) begin errors++; $display("wrong value %s exp %h got %h", nm, e, s); end end
module dsk_top_tb_top import dsk_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------
    // Bench signals and instances
    // ------------------------------------------------------------
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 8'h00, level = 8'h00, stat;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, seek_start, slverr;
    logic [7:0]  temp_code, options;
    logic [15:0] seek_cyl, sk_cyl;
    logic [3:0]  seek_head, sk_hd;
    int          errors = 0, n_tests = 0, cyc = 0, exp_opt = 'h43, sk_n = 0;
    logic [7:0]  fcs [19] = '{8'h02, 8'h82, 8'h02, 8'h03, 8'h05, 8'h85, 8'h06, 8'h07, 8'h10, 8'h90,
                              8'h43, 8'h4A, 8'h55, 8'hAA, 8'h66, 8'hCC, 8'h86, 8'h11, 8'hFF};

    dsk_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .temp_code(temp_code), .seek_cyl(seek_cyl), .seek_head(seek_head), .seek_start(seek_start),
        .options(options));
    dsk_temp_src sens_u (.pclk(pclk), .presetn(presetn), .level(level), .temp_code(temp_code));

    // Clock
    always #25 pclk = ~pclk;

    // Seek start capture and hang guard, sampled mid-cycle where outputs are settled
    always @(negedge pclk) begin
        cyc++;
        if (seek_start === 1'b1) begin
            sk_cyl = seek_cyl;
            sk_hd = seek_head;
            sk_n++;
        end
        if (cyc == 20000) begin
            errors++;
            final_report();
        end
    end

    task automatic final_report;
        $display("mismatches %0d of %0d checks", errors, n_tests);
        if (errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // One APB transfer, request held until pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        slverr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Issue a command, poll until not busy, leave error byte in rd
    task automatic cmd(input logic [7:0] op);
        int k;
        k = 0;
        apb(1'b1, OFF_COMMAND, {24'h0, op});
        do begin
            apb(1'b0, OFF_STATUS, 32'h0);
            k++;
        end while (rd[ST_BUSY_BIT] === 1'b1 && k < 40);
        `CHK("busy", 1'b0, rd[ST_BUSY_BIT])
        stat = rd[7:0];
        apb(1'b0, OFF_ERROR, 32'h0);
    endtask

    // Set-features with the option model kept in step
    task automatic setf(input logic [7:0] fc, input logic [7:0] sc);
        logic ab;
        ab = 1'b0;
        case (fc)
            8'h02: exp_opt |= 'h01;
            8'h82: exp_opt &= 'hFE;
            8'h55: exp_opt &= 'hFD;
            8'hAA: exp_opt |= 'h02;
            8'h66: exp_opt &= 'hFB;
            8'hCC: exp_opt |= 'h04;
            8'h05: exp_opt |= 'h10;
            8'h85: exp_opt &= 'hEF;
            8'h06: exp_opt |= 'h20;
            8'h86: exp_opt &= 'hDF;
            8'h07: exp_opt |= 'h40;
            8'h4A: exp_opt |= 'h80;
            8'h03, 8'h10, 8'h90, 8'h43: ab = 1'b0;
            default: ab = 1'b1;
        endcase
        apb(1'b1, OFF_FEATURE, {24'h0, fc});
        apb(1'b1, OFF_SECT_CNT, {24'h0, sc});
        cmd(OPC_SET_FEATURE);
        `CHK("abort", {5'h0, ab, 2'h0}, rd[7:0])
        `CHK("err flag", ab, stat[ST_ERR_BIT])
        apb(1'b0, OFF_OPTIONS, 32'h0);
        `CHK("options", exp_opt[7:0], rd[7:0])
        if (fc == 8'h03) begin
            apb(1'b0, OFF_XFER_MODE, 32'h0);
            `CHK("xfer mode", sc, rd[7:0])
        end
        if (fc == 8'h10 || fc == 8'h90) begin
            apb(1'b0, OFF_SATA_EN, 32'h0);
            `CHK("serial feature", fc == 8'h10, rd[sc[2:0]])
        end
        // Address registers are still cleared here, so only the low byte carries data
        if (fc == 8'h43) begin
            apb(1'b0, OFF_SECT_TIME, 32'h0);
            `CHK("sector time", {24'h0, sc}, rd)
        end
    endtask

    // Temperature sense with a given sensor code
    task automatic temp(input logic [7:0] lv, input logic [7:0] fe);
        level <= lv;
        repeat (2) @(posedge pclk);
        apb(1'b1, OFF_FEATURE, {24'h0, fe});
        cmd(OPC_TEMP_SENSE);
        `CHK("temp error", (fe == 8'h01) ? 8'h00 : 8'h04, rd[7:0])
        apb(1'b0, OFF_SECT_CNT, 32'h0);
        if (fe == 8'h01) `CHK("temp code", lv, rd[7:0])
    endtask

    // Seek in block or cylinder/head mode, xe is the expected error byte
    task automatic seek(input logic lm, input logic [27:0] a, input logic [7:0] xe);
        int n0;
        n0 = sk_n;
        apb(1'b1, OFF_SECT_NUM, {24'h0, a[7:0]});
        apb(1'b1, OFF_CYL_LOW, {24'h0, a[15:8]});
        apb(1'b1, OFF_CYL_HIGH, {24'h0, a[23:16]});
        apb(1'b1, OFF_DEV_HEAD, {24'h0, 1'b1, lm, 2'b10, a[27:24]});
        cmd({OPC_POSITION_HI, 4'($urandom_range(15))});
        `CHK("seek error", xe, rd[7:0])
        `CHK("seek done", xe == 8'h00, stat[ST_POSDONE_BIT])
        `CHK("seek starts", n0 + 1, sk_n)
        `CHK("seek cyl", a[23:8], sk_cyl)
        `CHK("seek head", a[27:24], sk_hd)
        if (lm && xe == 8'h00) begin
            apb(1'b0, OFF_SECT_NUM, 32'h0);
            `CHK("lba 7:0", a[7:0], rd[7:0])
            apb(1'b0, OFF_CYL_LOW, 32'h0);
            `CHK("lba 15:8", a[15:8], rd[7:0])
            apb(1'b0, OFF_CYL_HIGH, 32'h0);
            `CHK("lba 23:16", a[23:16], rd[7:0])
            apb(1'b0, OFF_DEV_HEAD, 32'h0);
            `CHK("lba 27:24", a[27:24], rd[3:0])
        end
    endtask

    // Main sequence
    initial begin
        void'($urandom(6));
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        `CHK("options reset", 8'h43, options)
        apb(1'b0, OFF_STATUS, 32'h0);
        `CHK("status reset", 8'h40, rd[7:0])
        $display("test reset done");
        foreach (fcs[i]) setf(fcs[i], 8'($urandom_range(255)));
        $display("test set features done");
        setf(8'h06, 8'h00);
        temp(8'h00, 8'h01);
        temp(8'hFF, 8'h01);
        temp(8'($urandom_range(254, 1)), 8'h01);
        temp(8'h33, 8'h02);
        $display("test temperature done");
        seek(1'b1, 28'($urandom), 8'h00);
        seek(1'b1, 28'hFFFFFFF, 8'h00);
        seek(1'b0, 28'h5123400, 8'h00);
        apb(1'b1, OFF_POS_CTRL, 32'h100);
        seek(1'b1, 28'h0000200, 8'h10);
        $display("test seek done");
        apb(1'b0, 8'h3C, 32'h0);
        `CHK("unmapped err", 1'b1, slverr)
        `CHK("unmapped data", 32'h0, rd)
        $display("test unmapped done");
        cmd(8'h20);
        `CHK("unknown op", 8'h04, rd[7:0])
        `CHK("unknown op err", 1'b1, stat[ST_ERR_BIT])
        $display("test unknown opcode done");
        // Hard reset in mid-run brings back the feature defaults
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        exp_opt = 'h43;
        apb(1'b0, OFF_OPTIONS, 32'h0);
        `CHK("options hard reset", exp_opt[7:0], rd[7:0])
        apb(1'b0, OFF_POS_CTRL, 32'h0);
        `CHK("max lba reset", 32'h0FFF_FFFF, rd)
        $display("test hard reset done");
        final_report();
    end
endmodule
`default_nettype wire
